// file: pkg/pwr_wake_defines.vh
`ifndef PWR_WAKE_DEFINES_VH
`define PWR_WAKE_DEFINES_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ 25000000
`define SHORT_PRESS_S 4
`define LONG_PRESS_S 6
`define DEBOUNCE_US 20
`define DEBOUNCE_CYC ((`DEBOUNCE_US * (`CLK_HZ / 1000000)) < 1 ? 1 : (`DEBOUNCE_US * (`CLK_HZ / 1000000)))
`define SHORT_PRESS_CYC (`SHORT_PRESS_S * `CLK_HZ)
`define LONG_PRESS_CYC (`LONG_PRESS_S * `CLK_HZ)
`define SETTLE_MS 100
`define SETTLE_CYC (`SETTLE_MS * (`CLK_HZ / 1000))

// ----------------------------------------------------------------------------
// System states
// ----------------------------------------------------------------------------
`define ST_W 3
`define ST_OFF 3'h0
`define ST_S0 3'h1
`define ST_S3 3'h2
`define ST_S4 3'h3
`define ST_S5 3'h4

// ----------------------------------------------------------------------------
// Indicator colours
// ----------------------------------------------------------------------------
`define LED_W 2
`define LED_DARK 2'h0
`define LED_GREEN 2'h1
`define LED_AMBER 2'h2

`endif

// file: src/press_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "pwr_wake_defines.vh"

// Debounces the power switch, pulses short_o at a quick release and long_o while still held past the long limit.
module press_timer #(
  parameter DEB_CYC = `DEBOUNCE_CYC,
  parameter SHORT_CYC = `SHORT_PRESS_CYC,
  parameter LONG_CYC = `LONG_PRESS_CYC
) (
  input wire ref_clk_i, // Clock.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire ce_i, // Clock enable.
  input wire btn_n_i, // Raw switch, low while pressed.
  output reg short_o, // Pulse: released before the short limit.
  output reg long_o // Pulse: held past the long limit.
);
  reg [31:0] deb_cnt_r;
  reg [31:0] hold_cnt_r;
  reg pressed_r;
  reg long_done_r;

  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      deb_cnt_r <= 32'h0;
      hold_cnt_r <= 32'h0;
      pressed_r <= 1'b0;
      long_done_r <= 1'b0;
      short_o <= 1'b0;
      long_o <= 1'b0;
    end
    else if (ce_i)
    begin
      short_o <= 1'b0;
      long_o <= 1'b0;
      if ((!btn_n_i) == pressed_r)
        deb_cnt_r <= 32'h0;
      else if (deb_cnt_r >= DEB_CYC - 1)
      begin
        deb_cnt_r <= 32'h0;
        pressed_r <= !btn_n_i;
        if (pressed_r && !long_done_r && hold_cnt_r < SHORT_CYC)
          short_o <= 1'b1;
        hold_cnt_r <= 32'h0;
        long_done_r <= 1'b0;
      end
      else
        deb_cnt_r <= deb_cnt_r + 32'h1;
      if (pressed_r && !long_done_r && (!btn_n_i) == pressed_r)
      begin
        hold_cnt_r <= hold_cnt_r + 32'h1;
        if (hold_cnt_r >= LONG_CYC - 1)
        begin
          long_o <= 1'b1;
          long_done_r <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: src/power_button_wake_control.v
`timescale 1ns/1ps
`default_nettype none
`include "pwr_wake_defines.vh"

// What this block does
// - Short press: off to on, sleep to on, on to sleep or off by setting.
// - Hold past six seconds while on or sleeping forces soft-off.
// - Next state depends on present state and measured press length.
// - Network and PCIe wake from S3, S4, S5; USB wake only from S3.
// - Network and PCIe wakes ignored right after AC return until settled.
// - On AC return restore prior on/off state unless configuration overrides.
// - Main supply stays disabled in S3.
// - In S3 indicator amber if two-colour, dark if single-colour.
// - Permitted wake in S3 returns to the last working state.
// - USB bus activity wakes the system from S3.
// - Real-time clock alarm wakes the system from S5.
module power_button_wake_control #(
  parameter DEB_CYC = `DEBOUNCE_CYC,
  parameter SHORT_CYC = `SHORT_PRESS_CYC,
  parameter LONG_CYC = `LONG_PRESS_CYC,
  parameter SETTLE_CYC = `SETTLE_CYC
) (
  input wire ref_clk_i, // Clock, 25 MHz.
  input wire rst_n_i, // Synchronous reset, active low.
  input wire ce_i, // Clock enable, freezes state when low.
  input wire btn_n_i, // Power switch, low while pressed.
  input wire lan_wake_i, // Network wake request, active high.
  input wire pcie_wake_n_i, // PCIe wake, active low.
  input wire usb_wake_i, // USB bus activity, active high.
  input wire rtc_alarm_i, // Real-time clock alarm reached, active high.
  input wire os_sleep_i, // OS request: enter sleep, pulse.
  input wire os_sleep_s4_i, // With os_sleep_i: sleep to disk rather than RAM.
  input wire os_off_i, // OS request: soft-off, pulse.
  input wire cfg_btn_off_i, // Short press while on goes to soft-off, else S3.
  input wire cfg_restore_en_i, // Restore last state after AC loss.
  input wire cfg_ac_on_i, // Forced state after AC loss when restore is off.
  input wire last_on_i, // Battery-kept record: system was on at AC loss.
  input wire led_dual_i, // Two-colour indicator fitted.
  output reg psu_on_o, // Main supply enable.
  output reg [`LED_W-1:0] led_o, // Indicator colour.
  output reg sleep_o, // High while in S3 or S4.
  output reg [`ST_W-1:0] state_o, // Present system state.
  output reg last_on_o // Record of on state for the battery store.
);
  // --------------------------------------------------------------------------
  // Press timing
  // --------------------------------------------------------------------------
  wire short_p;
  wire long_p;

  press_timer #(
    .DEB_CYC(DEB_CYC),
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_press (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .btn_n_i(btn_n_i),
    .short_o(short_p),
    .long_o(long_p)
  );

  // --------------------------------------------------------------------------
  // Wake qualification
  // --------------------------------------------------------------------------
  reg [`ST_W-1:0] state_r;
  reg [`ST_W-1:0] state_nxt;
  reg boot_r;
  reg [31:0] settle_cnt_r;
  reg settled_r;
  wire pcie_wake;
  wire net_wake;
  wire wake_s3;
  wire wake_s4;
  wire wake_s5;
  wire restore_on;

  assign pcie_wake = !pcie_wake_n_i;

  // Network and PCIe sources stay masked until standby has settled after AC return.
  assign net_wake = settled_r && (lan_wake_i || pcie_wake);

  // USB activity only counts in S3, the alarm only in S5.
  assign wake_s3 = short_p || net_wake || usb_wake_i;
  assign wake_s4 = short_p || net_wake;
  assign wake_s5 = short_p || net_wake || rtc_alarm_i;

  // The restore setting picks the battery record, otherwise the forced choice wins.
  assign restore_on = cfg_restore_en_i ? last_on_i : cfg_ac_on_i;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      `ST_OFF:
      begin
        if (restore_on)
          state_nxt = `ST_S0;
        else
          state_nxt = `ST_S5;
      end
      `ST_S0:
      begin
        if (long_p)
          state_nxt = `ST_S5;
        else if (short_p && cfg_btn_off_i)
          state_nxt = `ST_S5;
        else if (short_p)
          state_nxt = `ST_S3;
        else if (os_off_i)
          state_nxt = `ST_S5;
        else if (os_sleep_i && os_sleep_s4_i)
          state_nxt = `ST_S4;
        else if (os_sleep_i)
          state_nxt = `ST_S3;
      end
      `ST_S3:
      begin
        if (long_p)
          state_nxt = `ST_S5;
        else if (wake_s3)
          state_nxt = `ST_S0;
      end
      `ST_S4:
      begin
        if (long_p)
          state_nxt = `ST_S5;
        else if (wake_s4)
          state_nxt = `ST_S0;
      end
      `ST_S5:
      begin
        if (wake_s5)
          state_nxt = `ST_S0;
      end
      default:
        state_nxt = `ST_S5;
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // The boot flag holds the restore decision back one cycle after AC return,
  // so the configuration and record inputs are settled when they are used.
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= `ST_OFF;
      boot_r <= 1'b1;
    end
    else if (ce_i)
    begin
      boot_r <= 1'b0;
      if (!boot_r)
        state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Settle timer
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      settle_cnt_r <= 32'h0;
      settled_r <= 1'b0;
    end
    else if (ce_i && !settled_r)
    begin
      settle_cnt_r <= settle_cnt_r + 32'h1;
      if (settle_cnt_r >= SETTLE_CYC - 1)
        settled_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Supply, sleep and state outputs
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      psu_on_o <= 1'b0;
      sleep_o <= 1'b0;
      state_o <= `ST_OFF;
    end
    else if (ce_i)
    begin
      psu_on_o <= (state_r == `ST_S0);
      sleep_o <= (state_r == `ST_S3) || (state_r == `ST_S4);
      state_o <= state_r;
    end
  end

  // --------------------------------------------------------------------------
  // Indicator
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      led_o <= `LED_DARK;
    else if (ce_i)
    begin
      if (state_r == `ST_S0)
        led_o <= `LED_GREEN;
      else if (state_r == `ST_S3 && led_dual_i)
        led_o <= `LED_AMBER;
      else
        led_o <= `LED_DARK;
    end
  end

  // --------------------------------------------------------------------------
  // On-state record
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      last_on_o <= 1'b0;
    else if (ce_i)
    begin
      if (state_r == `ST_S0)
        last_on_o <= 1'b1;
      else if (state_r == `ST_S5 || state_r == `ST_S4)
        last_on_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/pbwc_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_wake_defines.vh"
module pbwc_sva (
  input wire logic ref_clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic led_dual_i, // Two-colour indicator.
  input wire logic psu_on_o, // Supply enable.
  input wire logic [`LED_W-1:0] led_o, // Indicator.
  input wire logic sleep_o, // Sleep flag.
  input wire logic [`ST_W-1:0] state_o, // State.
  input wire logic last_on_o // On record.
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  psu_s3_off_a: assert property (state_o == `ST_S3 |-> !psu_on_o)
    else $error("supply on in S3");
  psu_s0_a: assert property (psu_on_o == (state_o == `ST_S0))
    else $error("supply not tied to S0");
  led_amber_a: assert property (state_o == `ST_S3 && $past(led_dual_i) |-> led_o == `LED_AMBER)
    else $error("indicator not amber");
  led_dark_a: assert property (state_o == `ST_S3 && !$past(led_dual_i) |-> led_o == `LED_DARK)
    else $error("indicator not dark");
  s3_exit_a: assert property ($past(state_o) == `ST_S3 && state_o != `ST_S3 |->
    state_o == `ST_S0 || state_o == `ST_S5) else $error("bad exit from S3");
  s5_exit_a: assert property ($past(state_o) == `ST_S5 && state_o != `ST_S5 |-> state_o == `ST_S0)
    else $error("bad exit from S5");
  boot_exit_a: assert property ($past(state_o) == `ST_OFF && state_o != `ST_OFF |->
    state_o == `ST_S0 || state_o == `ST_S5) else $error("bad state after boot");
  sleep_flag_a: assert property (sleep_o == (state_o == `ST_S3 || state_o == `ST_S4))
    else $error("sleep flag wrong");
  last_on_a: assert property (state_o == `ST_S0 |-> ##[0:2] last_on_o)
    else $error("on record not set");
  s3_seen_c: cover property (state_o == `ST_S3);
  s4_seen_c: cover property (state_o == `ST_S4);
  s5_wake_c: cover property ($past(state_o) == `ST_S5 && state_o == `ST_S0);
endmodule
bind power_button_wake_control pbwc_sva u_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .led_dual_i(led_dual_i), .psu_on_o(psu_on_o), .led_o(led_o), .sleep_o(sleep_o),
  .state_o(state_o), .last_on_o(last_on_o));
`default_nettype wire

// file: testbench/panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module panel_model (
  input wire logic clk_i, // Clock.
  output logic btn_n_o, // Switch, low pressed.
  output logic [3:0] wk_o // Network, PCIe low, USB, alarm.
);
  initial btn_n_o = 1'b1;
  initial wk_o = 4'h2;
  task press(input int n);
    @(posedge clk_i) #1 btn_n_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1 btn_n_o = 1'b1;
  endtask
  // Raises one wake source for three cycles; source 0 is the network frame match.
  task wake(input int k);
    @(posedge clk_i) #1 wk_o = 4'h2 ^ (4'h1 << k);
    repeat (3) @(posedge clk_i);
    #1 wk_o = 4'h2;
  endtask
endmodule
`default_nettype wire

// file: testbench/power_button_wake_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_wake_defines.vh"
module power_button_wake_control_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sl = 1'b0;
  logic s4 = 1'b0;
  logic off = 1'b0;
  logic dual = 1'b1;
  logic ce = 1'b1;
  logic cfg_off = 1'b0;
  logic cfg_rst = 1'b1;
  logic cfg_ac = 1'b0;
  logic last_in = 1'b0;
  logic btn_n, psu, slp, lst;
  logic [3:0] wk;
  logic [1:0] led;
  logic [2:0] st;
  int fail_count = 0;
  int n_tests = 0;
  initial
  begin
    forever #20 clk = ~clk;
  end
  panel_model pm (.clk_i(clk), .btn_n_o(btn_n), .wk_o(wk));
  power_button_wake_control #(.DEB_CYC(2), .SHORT_CYC(40), .LONG_CYC(60), .SETTLE_CYC(10)) uut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .btn_n_i(btn_n), .lan_wake_i(wk[0]),
    .pcie_wake_n_i(wk[1]), .usb_wake_i(wk[2]), .rtc_alarm_i(wk[3]), .os_sleep_i(sl),
    .os_sleep_s4_i(s4), .os_off_i(off), .cfg_btn_off_i(cfg_off), .cfg_restore_en_i(cfg_rst),
    .cfg_ac_on_i(cfg_ac), .last_on_i(last_in), .led_dual_i(dual), .psu_on_o(psu), .led_o(led),
    .sleep_o(slp), .state_o(st), .last_on_o(lst));
  task tally_and_finish;
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wait_st(input logic [2:0] e);
    for (int i = 0; i < 40 && st !== e; i++)
      #40;
    cmp(st, e);
  endtask
  task t_restore;
    pm.wake(0);
    #400 cmp(st, `ST_S5);
    pm.wake(2);
    #400 cmp(st, `ST_S5);
  endtask
  task t_on;
    pm.press(10);
    wait_st(`ST_S0);
    cmp({psu, led}, {1'b1, `LED_GREEN});
    pm.press(50);
    #400 cmp(st, `ST_S0);
  endtask
  task t_s3;
    pm.press(10);
    wait_st(`ST_S3);
    cmp({psu, led}, {1'b0, `LED_AMBER});
    cmp({1'b0, slp, lst}, 3'h3);
    dual = 1'b0;
    #120 cmp({psu, led}, {1'b0, `LED_DARK});
    dual = 1'b1;
    pm.wake(2);
    wait_st(`ST_S0);
    pm.press(10);
    wait_st(`ST_S3);
    pm.wake(1);
    wait_st(`ST_S0);
  endtask
  task t_s4;
    sl = 1'b1;
    s4 = 1'b1;
    #40 sl = 1'b0;
    s4 = 1'b0;
    wait_st(`ST_S4);
    cmp({1'b0, slp, lst}, 3'h2);
    pm.wake(2);
    #400 cmp(st, `ST_S4);
    pm.wake(0);
    wait_st(`ST_S0);
  endtask
  task t_off;
    off = 1'b1;
    #40 off = 1'b0;
    wait_st(`ST_S5);
    cmp({1'b0, slp, lst}, 3'h0);
    pm.wake(3);
    wait_st(`ST_S0);
    pm.press(80);
    wait_st(`ST_S5);
  endtask
  task t_freeze;
    ce = 1'b0;
    pm.press(10);
    #400 cmp(st, `ST_S0);
    cmp({psu, led}, {1'b1, `LED_GREEN});
    ce = 1'b1;
    #400 cmp(st, `ST_S0);
  endtask
  task t_cfg;
    cfg_off = 1'b1;
    pm.press(10);
    wait_st(`ST_S5);
    cmp({psu, led}, {1'b0, `LED_DARK});
    cfg_off = 1'b0;
    pm.press(10);
    wait_st(`ST_S0);
  endtask
  task reboot(input logic r, input logic a, input logic l, input logic [2:0] e);
    @(posedge clk) #1 rst_n = 1'b0;
    cfg_rst = r;
    cfg_ac = a;
    last_in = l;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    cmp({psu, led}, {1'b0, `LED_DARK});
    cmp(st, `ST_OFF);
    wait_st(e);
  endtask
  task t_reboot;
    reboot(1'b1, 1'b0, 1'b1, `ST_S0);
    reboot(1'b0, 1'b1, 1'b0, `ST_S0);
    reboot(1'b0, 1'b0, 1'b1, `ST_S5);
    pm.wake(1);
    #400 cmp(st, `ST_S5);
  endtask
  initial
  begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    t_restore;
    t_on;
    t_freeze;
    t_cfg;
    t_s3;
    t_s4;
    t_off;
    t_reboot;
    tally_and_finish;
  end
endmodule
`default_nettype wire
